// ---- core/pkrs_hold_timer.sv ----
// low level hold timer with one-shot expiry
`timescale 1ns/1ps
`include "pkrs_cfg.svh"
module pkrs_hold_timer
(
	// clock and reset
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	// level and limit
	input wire logic i_low,
	input wire logic [`PKRS_CNT_W-1:0] i_limit,
	// expiry pulse, once per low level
	output logic o_fire
);
	logic [`PKRS_CNT_W-1:0] cnt_q;
	logic done_q;
	logic fire_q;
	wire reach = (cnt_q == i_limit - `PKRS_CNT_W'(1));
	wire hit = i_low && !done_q && reach;
	assign o_fire = fire_q;
	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			cnt_q <= '0;
			done_q <= 1'b0;
			fire_q <= 1'b0;
		end
		else if (i_ce)
		begin
			cnt_q <= (i_low && !done_q && !reach) ? cnt_q + 1'b1 : '0;
			done_q <= i_low && (done_q || hit);
			fire_q <= hit;
		end
	end
endmodule

// ---- core/pkrs_sequencer.sv ----
// power key and hard reset sequencing state machine
`timescale 1ns/1ps
`include "pkrs_cfg.svh"
module pkrs_sequencer
#(
	parameter int ON_CYC = `PKRS_ON_CYC,
	parameter int OFF_CYC = `PKRS_OFF_CYC,
	parameter int RST_CYC = `PKRS_RST_CYC,
	parameter int LOGOUT_CYC = `PKRS_LOGOUT_CYC
)
(
	// clock, reset, enable
	input wire logic i_mclk,
	input wire logic i_rst_n,
	input wire logic i_ce,
	// control pins
	input wire logic i_power_key_n,
	input wire logic i_hw_reset_n,
	// battery monitor and commands
	input wire logic [`PKRS_MV_W-1:0] i_battery_mv,
	input wire logic i_power_down_command,
	input wire logic i_battery_threshold_command,
	input wire logic [`PKRS_MV_W-1:0] i_battery_threshold_mv,
	// status
	output logic o_io_rail_out,
	output pkrs_pkg::pkrs_status_t o_status
);
	pkrs_pkg::pkrs_state_t state_q;
	pkrs_pkg::pkrs_state_t state_d;
	logic [`PKRS_MV_W-1:0] off_mv_q;
	logic [`PKRS_CNT_W-1:0] lg_q;
	logic rail_q;
	pkrs_pkg::pkrs_status_t st_q;
	logic key_low;
	logic rst_low;
	logic on_fire;
	logic off_fire;
	logic rst_fire;
	logic key_fire;
	logic bat_ok;
	logic bat_low;
	logic lg_done;
	logic in_off;
	logic in_run;

	assign key_low = !i_power_key_n;
	assign rst_low = !i_hw_reset_n;
	assign in_off = (state_q == pkrs_pkg::PKRS_OFF);
	assign in_run = (state_q == pkrs_pkg::PKRS_RUN);
	assign bat_ok = (i_battery_mv > `PKRS_START_MV);
	assign bat_low = (i_battery_mv < off_mv_q);
	assign lg_done = (lg_q == `PKRS_CNT_W'(LOGOUT_CYC - 1));
	assign on_fire = key_fire && in_off;
	assign off_fire = key_fire && in_run;

	// one timer serves the key; threshold depends on running state
	pkrs_hold_timer u_key
	(
		.i_mclk(i_mclk),
		.i_rst_n(i_rst_n),
		.i_ce(i_ce),
		.i_low(key_low),
		.i_limit(in_run ? `PKRS_CNT_W'(OFF_CYC) : `PKRS_CNT_W'(ON_CYC)),
		.o_fire(key_fire)
	);

	pkrs_hold_timer u_rst
	(
		.i_mclk(i_mclk),
		.i_rst_n(i_rst_n),
		.i_ce(i_ce),
		.i_low(rst_low),
		.i_limit(`PKRS_CNT_W'(RST_CYC)),
		.o_fire(rst_fire)
	);

	always_comb
	begin
		state_d = state_q;
		case (state_q)
			pkrs_pkg::PKRS_OFF:
				if (on_fire)
					state_d = pkrs_pkg::PKRS_CHECK;
			pkrs_pkg::PKRS_CHECK:
				state_d = bat_ok ? pkrs_pkg::PKRS_RUN
					: pkrs_pkg::PKRS_LOGOUT;
			pkrs_pkg::PKRS_RUN:
				if (off_fire || i_power_down_command || bat_low)
					state_d = pkrs_pkg::PKRS_LOGOUT;
			pkrs_pkg::PKRS_LOGOUT:
				if (lg_done)
					state_d = key_low ? pkrs_pkg::PKRS_CHECK
						: pkrs_pkg::PKRS_OFF;
			pkrs_pkg::PKRS_HWOFF:
				state_d = pkrs_pkg::PKRS_HWOFF;
			default:
				state_d = pkrs_pkg::PKRS_OFF;
		endcase
		if (rst_fire)
			state_d = pkrs_pkg::PKRS_HWOFF;
	end

	always_ff @(posedge i_mclk or negedge i_rst_n)
	begin
		if (!i_rst_n)
		begin
			state_q <= pkrs_pkg::PKRS_OFF;
			off_mv_q <= `PKRS_OFF_MV_RST;
			lg_q <= '0;
			rail_q <= 1'b0;
			st_q <= '0;
		end
		else if (i_ce)
		begin
			state_q <= state_d;
			if (i_battery_threshold_command)
				off_mv_q <= i_battery_threshold_mv;
			lg_q <= (state_q == pkrs_pkg::PKRS_LOGOUT && !lg_done)
				? lg_q + 1'b1 : '0;
			rail_q <= (state_d == pkrs_pkg::PKRS_RUN) ||
				(state_d == pkrs_pkg::PKRS_LOGOUT);
			st_q.on <= (state_d == pkrs_pkg::PKRS_RUN);
			st_q.busy <= (state_d == pkrs_pkg::PKRS_CHECK) ||
				(state_d == pkrs_pkg::PKRS_LOGOUT);
			st_q.hw_off <= (state_d == pkrs_pkg::PKRS_HWOFF);
		end
	end

	assign o_io_rail_out = rail_q;
	assign o_status = st_q;

	// checks
	default clocking cb @(posedge i_mclk); endclocking
	default disable iff (!i_rst_n);

	property p_rail_run;
		i_ce && state_q == pkrs_pkg::PKRS_RUN |-> rail_q;
	endproperty
	a_rail_run: assert property (p_rail_run)
		else $error("rail low while running");

	property p_start;
		in_off && on_fire && i_ce && !rst_fire ##1 1
			|-> state_q == pkrs_pkg::PKRS_CHECK;
	endproperty
	a_start: assert property (p_start)
		else $error("start not taken");

	property p_check;
		state_q == pkrs_pkg::PKRS_CHECK && i_ce && !rst_fire && !bat_ok
			|=> state_q == pkrs_pkg::PKRS_LOGOUT;
	endproperty
	a_check: assert property (p_check)
		else $error("low battery start not abandoned");

	property p_hwoff;
		state_q == pkrs_pkg::PKRS_HWOFF |=> state_q == pkrs_pkg::PKRS_HWOFF;
	endproperty
	a_hwoff: assert property (p_hwoff)
		else $error("left hardware off");

	property p_rst;
		rst_fire && i_ce |=> state_q == pkrs_pkg::PKRS_HWOFF;
	endproperty
	a_rst: assert property (p_rst)
		else $error("hard reset missed");

	property p_cmd;
		in_run && i_ce && i_power_down_command && !rst_fire
			|=> state_q == pkrs_pkg::PKRS_LOGOUT;
	endproperty
	a_cmd: assert property (p_cmd)
		else $error("power down command ignored");

	property p_lowbat;
		in_run && i_ce && bat_low && !rst_fire
			|=> state_q == pkrs_pkg::PKRS_LOGOUT;
	endproperty
	a_lowbat: assert property (p_lowbat)
		else $error("low battery shutdown missed");

	property p_once;
		key_fire |=> !key_fire;
	endproperty
	a_once: assert property (p_once)
		else $error("double key event");

	property p_nokey;
		in_off && i_ce && !on_fire && !rst_fire |=> in_off;
	endproperty
	a_nokey: assert property (p_nokey)
		else $error("off state left without key hold");

	property p_keyoff;
		in_run && i_ce && off_fire && !rst_fire
			|=> state_q == pkrs_pkg::PKRS_LOGOUT;
	endproperty
	a_keyoff: assert property (p_keyoff)
		else $error("key shutdown missed");

	property p_run;
		state_q == pkrs_pkg::PKRS_CHECK && i_ce && !rst_fire && bat_ok
			|=> in_run;
	endproperty
	a_run: assert property (p_run)
		else $error("good battery start not completed");

	property p_retry;
		state_q == pkrs_pkg::PKRS_LOGOUT && i_ce && lg_done && key_low
			&& !rst_fire |=> state_q == pkrs_pkg::PKRS_CHECK;
	endproperty
	a_retry: assert property (p_retry)
		else $error("grounded key restart missed");

	property p_stop;
		state_q == pkrs_pkg::PKRS_LOGOUT && i_ce && lg_done && !key_low
			&& !rst_fire |=> in_off;
	endproperty
	a_stop: assert property (p_stop)
		else $error("logout did not end in off");

	property p_logout_stay;
		state_q == pkrs_pkg::PKRS_LOGOUT && i_ce && !lg_done && !rst_fire
			|=> state_q == pkrs_pkg::PKRS_LOGOUT;
	endproperty
	a_logout_stay: assert property (p_logout_stay)
		else $error("logout cut short");

	property p_lg_zero;
		i_ce && state_q != pkrs_pkg::PKRS_LOGOUT |=> lg_q == '0;
	endproperty
	a_lg_zero: assert property (p_lg_zero)
		else $error("logout counter not cleared");

	property p_check_len;
		state_q == pkrs_pkg::PKRS_CHECK && i_ce
			|=> state_q != pkrs_pkg::PKRS_CHECK;
	endproperty
	a_check_len: assert property (p_check_len)
		else $error("battery check longer than one cycle");

	property p_on_st;
		st_q.on == in_run;
	endproperty
	a_on_st: assert property (p_on_st)
		else $error("on status disagrees with state");

	property p_busy_st;
		st_q.busy == (state_q == pkrs_pkg::PKRS_CHECK ||
			state_q == pkrs_pkg::PKRS_LOGOUT);
	endproperty
	a_busy_st: assert property (p_busy_st)
		else $error("busy status disagrees with state");

	property p_rail_st;
		rail_q == (in_run || state_q == pkrs_pkg::PKRS_LOGOUT);
	endproperty
	a_rail_st: assert property (p_rail_st)
		else $error("rail disagrees with state");

	property p_hw_st;
		st_q.hw_off == (state_q == pkrs_pkg::PKRS_HWOFF);
	endproperty
	a_hw_st: assert property (p_hw_st)
		else $error("hard off status disagrees with state");

	property p_fire_key;
		$rose(key_fire) |-> $past(key_low);
	endproperty
	a_fire_key: assert property (p_fire_key)
		else $error("key event without key low");

	property p_fire_rst;
		$rose(rst_fire) |-> $past(rst_low);
	endproperty
	a_fire_rst: assert property (p_fire_rst)
		else $error("reset event without reset low");

	property p_thr;
		i_ce && i_battery_threshold_command
			|=> off_mv_q == $past(i_battery_threshold_mv);
	endproperty
	a_thr: assert property (p_thr)
		else $error("threshold not loaded");

	c_start: cover property (state_q == pkrs_pkg::PKRS_RUN);
	c_retry: cover property (state_q == pkrs_pkg::PKRS_LOGOUT ##1
		state_q == pkrs_pkg::PKRS_CHECK);
	c_keyoff: cover property (in_run ##1
		state_q == pkrs_pkg::PKRS_LOGOUT);
	c_logout: cover property (state_q == pkrs_pkg::PKRS_LOGOUT);
	c_hwoff: cover property (state_q == pkrs_pkg::PKRS_HWOFF);
endmodule

// ---- inc/pkrs_cfg.svh ----
// constants for the power key and reset sequencer
`ifndef PKRS_CFG_SVH
`define PKRS_CFG_SVH
`define PKRS_CLK_HZ 10000000
`define PKRS_ON_HOLD_MS 1200
`define PKRS_OFF_HOLD_MS 1500
`define PKRS_RST_HOLD_MS 100
`define PKRS_LOGOUT_MS 2000
`define PKRS_MS_CYC (`PKRS_CLK_HZ / 1000)
`define PKRS_ON_CYC (`PKRS_ON_HOLD_MS * `PKRS_MS_CYC + 1)
`define PKRS_OFF_CYC (`PKRS_OFF_HOLD_MS * `PKRS_MS_CYC + 1)
`define PKRS_RST_CYC (`PKRS_RST_HOLD_MS * `PKRS_MS_CYC + 1)
`define PKRS_LOGOUT_CYC (`PKRS_LOGOUT_MS * `PKRS_MS_CYC)
`define PKRS_CNT_W 32
`define PKRS_MV_W 13
`define PKRS_START_MV 13'h0C1C
`define PKRS_OFF_MV_RST 13'h0C1C
`endif

// ---- inc/pkrs_pkg.sv ----
// types for the power key and reset sequencer
package pkrs_pkg;
	typedef enum logic [2:0] {
		PKRS_OFF = 3'h0,
		PKRS_CHECK = 3'h1,
		PKRS_RUN = 3'h2,
		PKRS_LOGOUT = 3'h3,
		PKRS_HWOFF = 3'h4
	} pkrs_state_t;
	typedef struct packed {
		logic on;
		logic busy;
		logic hw_off;
	} pkrs_status_t;
endpackage

// ---- testbench/pkrs_host_model.sv ----
// host controller model driving the key and reset pins
`timescale 1ns/1ps
module pkrs_host_model
(
	// clock
	input wire logic i_mclk,
	// requests from the bench
	input wire logic i_press,
	input wire logic i_reset_req,
	// control pins
	output logic o_power_key_n,
	output logic o_hw_reset_n
);
	initial
	begin
		o_power_key_n = 1'b1;
		o_hw_reset_n = 1'b1;
	end
	// pins move on the falling edge, away from sampling
	always @(negedge i_mclk)
	begin
		o_power_key_n <= !i_press;
		o_hw_reset_n <= !i_reset_req;
	end
endmodule

// ---- testbench/pkrs_sequencer_tb_top.sv ----
// self-checking bench for the power key and reset sequencer
`timescale 1ns/1ps
module pkrs_sequencer_tb_top;
	localparam int ON = 10, OFF = 12, RST = 8, LOG = 20;
	logic mclk = 0, rst_n = 0, press = 0, rst_req = 0, pd = 0, thr = 0;
	logic key_n, hw_n, rail;
	logic ce = 1;
	logic [12:0] batt = 13'h0FA0, thr_mv = 13'h0DAC;
	pkrs_pkg::pkrs_status_t st;
	int error_cnt = 0, compares = 0, n;
	initial
	begin
		forever #50 mclk = ~mclk;
	end
	pkrs_host_model pkrs_host_model_i (.i_mclk(mclk), .i_press(press),
		.i_reset_req(rst_req), .o_power_key_n(key_n), .o_hw_reset_n(hw_n));
	pkrs_sequencer #(.ON_CYC(ON), .OFF_CYC(OFF), .RST_CYC(RST),
		.LOGOUT_CYC(LOG)) pkrs_sequencer_i (.i_mclk(mclk), .i_rst_n(rst_n),
		.i_ce(ce), .i_power_key_n(key_n), .i_hw_reset_n(hw_n),
		.i_battery_mv(batt), .i_power_down_command(pd),
		.i_battery_threshold_command(thr), .i_battery_threshold_mv(thr_mv),
		.o_io_rail_out(rail), .o_status(st));
	task automatic chk(input string nm, input logic [12:0] s, e);
		compares++;
		if (s !== e)
		begin
			error_cnt++;
			$display("Error %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic cyc(input int k);
		repeat (k) @(negedge mclk);
	endtask
	task automatic wait_rail(input logic v, input int lim);
		n = 0;
		while (rail !== v && n < lim)
		begin
			cyc(1);
			n++;
		end
	endtask
	task automatic pwr_on;
		press = 1;
		wait_rail(1, 40);
		chk("on delay", 13'(n >= ON), 1);
		chk("status on", st.on, 1);
		press = 0;
		cyc(5);
	endtask
	task automatic t_short;
		press = 1;
		cyc(ON - 4);
		press = 0;
		cyc(30);
		chk("short press", rail, 0);
		pd = 1;
		cyc(1);
		pd = 0;
		cyc(10);
		chk("cmd while off", rail, 0);
		ce = 0;
		press = 1;
		cyc(ON + 5);
		press = 0;
		cyc(3);
		ce = 1;
		cyc(5);
		chk("frozen hold", rail, 0);
	endtask
	task automatic t_key_off;
		pwr_on();
		press = 1;
		cyc(OFF - 4);
		press = 0;
		cyc(10);
		chk("short off press", rail, 1);
		press = 1;
		n = 0;
		while (st.busy !== 1'b1 && n < OFF + 10)
		begin
			cyc(1);
			n++;
		end
		press = 0;
		chk("logout busy", st.busy, 1);
		chk("rail in logout", rail, 1);
		wait_rail(0, LOG + 10);
		chk("logout length", 13'(n >= LOG - 2), 1);
		cyc(LOG + 10);
		chk("key off", rail, 0);
	endtask
	task automatic t_cmd;
		pwr_on();
		pd = 1;
		cyc(1);
		pd = 0;
		wait_rail(0, LOG + 10);
		chk("command off", rail, 0);
	endtask
	task automatic t_lowbat;
		logic seen;
		logic prev;
		int rises;
		seen = 0;
		prev = 0;
		rises = 0;
		batt = 13'h0BB8;
		press = 1;
		repeat (60)
		begin
			cyc(1);
			seen = seen | (st.busy === 1'b1);
			rises = rises + ((rail === 1'b1 && prev !== 1'b1) ? 1 : 0);
			prev = rail;
			chk("low start", st.on, 0);
		end
		chk("retry busy", seen, 1);
		chk("retry cycling", 13'(rises >= 2), 1);
		press = 0;
		cyc(LOG + 10);
		chk("low off", rail, 0);
		batt = 13'h0FA0;
	endtask
	task automatic t_thresh;
		pwr_on();
		thr = 1;
		cyc(1);
		thr = 0;
		batt = 13'h0DE0;
		cyc(10);
		chk("above threshold", rail, 1);
		batt = 13'h0D48;
		wait_rail(0, LOG + 20);
		chk("below threshold", rail, 0);
		batt = 13'h0FA0;
	endtask
	task automatic t_ground;
		press = 1;
		wait_rail(1, 40);
		pd = 1;
		cyc(1);
		pd = 0;
		wait_rail(0, LOG + 10);
		chk("grounded off", rail, 0);
		wait_rail(1, 40);
		chk("grounded restart", rail, 1);
		press = 0;
		cyc(5);
		pd = 1;
		cyc(1);
		pd = 0;
		cyc(LOG + 20);
		chk("released off", rail, 0);
	endtask
	task automatic t_reset;
		pwr_on();
		rst_req = 1;
		cyc(RST - 4);
		rst_req = 0;
		cyc(5);
		chk("short reset", rail, 1);
		rst_req = 1;
		cyc(RST + 6);
		rst_req = 0;
		chk("hard reset rail", rail, 0);
		chk("hard off", st.hw_off, 1);
		press = 1;
		cyc(30);
		chk("no restart", rail, 0);
		press = 0;
		rst_n = 0;
		cyc(2);
		rst_n = 1;
		cyc(2);
		chk("released", st.hw_off, 0);
	endtask
	task automatic final_report;
		$display("Comparisons %0d, mismatches %0d", compares, error_cnt);
		if (error_cnt == 0 && compares > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	initial
	begin
		cyc(6);
		rst_n = 1;
		cyc(2);
		t_short();
		t_key_off();
		t_cmd();
		t_lowbat();
		t_thresh();
		t_ground();
		t_reset();
		final_report();
	end
	initial
	begin
		#(100 * 5000);
		error_cnt++;
		final_report();
	end
endmodule
